// File: verilog/mon_cfg_pkg.sv
/*
  Constants for the two lockable monitor configuration registers.
  Assumes a byte-wide internal register port from the serial slave decoder.
*/
`default_nettype none
package mon_cfg_pkg;
  // Register offsets.
  localparam logic [7:0] TEMP_FORMAT_OVERTEMP_CONFIG_ADDR = 8'h7c;
  localparam logic [7:0] PIN_FUNCTION_ATTENUATOR_CONFIG_ADDR = 8'h7d;
  // Reset values.
  localparam logic [7:0] TEMP_FORMAT_OVERTEMP_CONFIG_RST = 8'h05;
  localparam logic [7:0] PIN_FUNCTION_ATTENUATOR_CONFIG_RST = 8'h00;
  // Field positions of the format register.
  localparam int TWOS_COMP_SELECT_BIT = 0;
  localparam int OFFSET_RESOLUTION_SELECT_BIT = 1;
  localparam int ALERT_PIN_FUNCTION_LSB = 2;
  localparam int CPU_CONTROL_TEMP_OVERTEMP_EN_BIT = 4;
  localparam int REMOTE_ONE_OVERTEMP_EN_BIT = 5;
  localparam int LOCAL_OVERTEMP_EN_BIT = 6;
  localparam int REMOTE_TWO_OVERTEMP_EN_BIT = 7;
  // Field positions of the pin and divider register.
  localparam int TACH_PIN_FUNCTION_LSB = 0;
  localparam int OVERTEMP_OUTPUT_OFF_BIT = 2;
  localparam int DIVIDER_BYPASS_LSB = 3;
  // Alert pin function codes.
  localparam logic [1:0] ALERT_PIN_SMBALERT = 2'h0;
  localparam logic [1:0] ALERT_PIN_OVERTEMP = 2'h1;
  localparam logic [1:0] ALERT_PIN_SPARE_IO = 2'h2;
  // Tach pin function codes.
  localparam logic [1:0] TACH_PIN_FAN_SPEED = 2'h0;
  localparam logic [1:0] TACH_PIN_OVERTEMP = 2'h1;
  localparam logic [1:0] TACH_PIN_SMBALERT = 2'h2;
  // Limit values that switch a channel off in each encoding.
  localparam logic [7:0] LIMIT_OFF_OFFSET64 = 8'h00;
  localparam logic [7:0] LIMIT_OFF_TWOS = 8'h80;
  // Offset added to a signed reading in offset-64 mode.
  localparam logic [7:0] OFFSET64_BIAS = 8'h40;
endpackage : mon_cfg_pkg
`default_nettype wire

// File: verilog/mon_cfg_regs.sv
/*
  Format and pin-function configuration registers with overtemp, pin mux and
  divider outputs.
  Assumes the serial slave decodes bus cycles into a one-cycle write strobe,
  a byte address and data, and that the lock bit arrives from register 1.
  Temperatures and limits arrive as raw register codes in the current encoding.
*/
`default_nettype none
module mon_cfg_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic cfg_lock,
  input wire logic [7:0] cpu_temp,
  input wire logic [7:0] cpu_control_limit,
  input wire logic [7:0] remote_one_temp,
  input wire logic [7:0] remote_one_limit,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] local_limit,
  input wire logic [7:0] remote_two_temp,
  input wire logic [7:0] remote_two_limit,
  input wire logic smbalert_req,
  input wire logic spare_io_three_out,
  input wire logic spare_io_three_oe,
  output logic twos_comp_select,
  output logic offset_resolution_select,
  output logic overtemp_active,
  output logic overtemp_drive,
  output logic timer_input_only,
  output logic alert_pin_out,
  output logic alert_pin_oe,
  output logic tach_pin_out,
  output logic tach_pin_oe,
  output logic fan_four_speed_input_sel,
  output logic term_volt_divider_bypass,
  output logic v2p5_divider_bypass,
  output logic core_volt_divider_bypass,
  output logic v5_divider_bypass,
  output logic v12_divider_bypass
);
  // Stored register contents.
  logic [7:0] fmt_ff;
  logic [7:0] pin_ff;
  // Registered overtemp request so the pin is glitch free.
  logic ovt_ff;
  logic nxt_ovt;

  wire wr_ok = reg_wr && !cfg_lock;
  wire wr_fmt = wr_ok && (reg_addr == mon_cfg_pkg::TEMP_FORMAT_OVERTEMP_CONFIG_ADDR);
  wire wr_pin = wr_ok && (reg_addr == mon_cfg_pkg::PIN_FUNCTION_ATTENUATOR_CONFIG_ADDR);

  // Readback; unmapped addresses read zero.
  assign reg_rdata =
    (reg_addr == mon_cfg_pkg::TEMP_FORMAT_OVERTEMP_CONFIG_ADDR) ? fmt_ff :
    (reg_addr == mon_cfg_pkg::PIN_FUNCTION_ATTENUATOR_CONFIG_ADDR) ? pin_ff : 8'h00;

  assign twos_comp_select = fmt_ff[mon_cfg_pkg::TWOS_COMP_SELECT_BIT];
  assign offset_resolution_select = fmt_ff[mon_cfg_pkg::OFFSET_RESOLUTION_SELECT_BIT];

  // Flips bit 7 of a twos code (offset-64 codes pass unchanged) so one unsigned compare serves both modes.
  function automatic logic [7:0] to_ubias(input logic [7:0] code, input logic twos);
    to_ubias = twos ? (code ^ mon_cfg_pkg::LIMIT_OFF_TWOS) : code;
  endfunction : to_ubias

  function automatic logic limit_off(input logic [7:0] lim, input logic twos);
    limit_off = twos ? (lim == mon_cfg_pkg::LIMIT_OFF_TWOS)
                     : (lim == mon_cfg_pkg::LIMIT_OFF_OFFSET64);
  endfunction : limit_off

  // Per-channel over-limit with enable and disable value applied.
  function automatic logic chan_hot(input logic en, input logic [7:0] t,
                                    input logic [7:0] lim, input logic twos);
    chan_hot = en && !limit_off(lim, twos) && (to_ubias(t, twos) > to_ubias(lim, twos));
  endfunction : chan_hot

  wire tw = twos_comp_select;
  wire hot_cpu = chan_hot(fmt_ff[mon_cfg_pkg::CPU_CONTROL_TEMP_OVERTEMP_EN_BIT],
                          cpu_temp, cpu_control_limit, tw);
  wire hot_r1 = chan_hot(fmt_ff[mon_cfg_pkg::REMOTE_ONE_OVERTEMP_EN_BIT],
                         remote_one_temp, remote_one_limit, tw);
  wire hot_loc = chan_hot(fmt_ff[mon_cfg_pkg::LOCAL_OVERTEMP_EN_BIT],
                          local_temp, local_limit, tw);
  wire hot_r2 = chan_hot(fmt_ff[mon_cfg_pkg::REMOTE_TWO_OVERTEMP_EN_BIT],
                         remote_two_temp, remote_two_limit, tw);
  wire ovt_off = pin_ff[mon_cfg_pkg::OVERTEMP_OUTPUT_OFF_BIT];

  assign nxt_ovt = !ovt_off && (hot_cpu || hot_r1 || hot_loc || hot_r2);

  assign timer_input_only = ovt_off || (fmt_ff[7:4] == 4'h0);

  // Register writes; reset gives the power-on values.
  // power-on defaults
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      fmt_ff <= mon_cfg_pkg::TEMP_FORMAT_OVERTEMP_CONFIG_RST;
      pin_ff <= mon_cfg_pkg::PIN_FUNCTION_ATTENUATOR_CONFIG_RST;
      ovt_ff <= 1'b0;
    end
    else
    begin
      if (wr_fmt)
      begin
        fmt_ff <= reg_wdata;
      end
      if (wr_pin)
      begin
        pin_ff <= reg_wdata;
      end
      ovt_ff <= nxt_ovt;
    end
  end

  // The overtemp signal is active low on the wire and open drain.
  assign overtemp_active = ovt_ff;
  assign overtemp_drive = ovt_ff;

  wire [1:0] alert_sel = fmt_ff[mon_cfg_pkg::ALERT_PIN_FUNCTION_LSB +: 2];
  wire [1:0] tach_sel = pin_ff[mon_cfg_pkg::TACH_PIN_FUNCTION_LSB +: 2];

  assign alert_pin_out =
    (alert_sel == mon_cfg_pkg::ALERT_PIN_SPARE_IO) ? spare_io_three_out : 1'b0;
  assign alert_pin_oe =
    (alert_sel == mon_cfg_pkg::ALERT_PIN_SMBALERT) ? smbalert_req :
    (alert_sel == mon_cfg_pkg::ALERT_PIN_OVERTEMP) ? ovt_ff :
    (alert_sel == mon_cfg_pkg::ALERT_PIN_SPARE_IO) ? spare_io_three_oe : 1'b0;

  assign tach_pin_out = 1'b0;
  assign tach_pin_oe =
    (tach_sel == mon_cfg_pkg::TACH_PIN_OVERTEMP) ? ovt_ff :
    (tach_sel == mon_cfg_pkg::TACH_PIN_SMBALERT) ? smbalert_req : 1'b0;
  assign fan_four_speed_input_sel = (tach_sel == mon_cfg_pkg::TACH_PIN_FAN_SPEED);

  assign term_volt_divider_bypass = pin_ff[mon_cfg_pkg::DIVIDER_BYPASS_LSB];
  assign v2p5_divider_bypass = pin_ff[mon_cfg_pkg::DIVIDER_BYPASS_LSB + 1];
  assign core_volt_divider_bypass = pin_ff[mon_cfg_pkg::DIVIDER_BYPASS_LSB + 2];
  assign v5_divider_bypass = pin_ff[mon_cfg_pkg::DIVIDER_BYPASS_LSB + 3];
  assign v12_divider_bypass = pin_ff[mon_cfg_pkg::DIVIDER_BYPASS_LSB + 4];

  // Locked write leaves both registers unchanged.
  property p_lock_hold;
    @(posedge mclk) disable iff (reset)
    (reg_wr && cfg_lock) |=> (fmt_ff == $past(fmt_ff)) && (pin_ff == $past(pin_ff));
  endproperty
  a_p_lock_hold: assert property (p_lock_hold) else $error("locked write changed config");

  // Unlocked write to the format register lands next cycle.
  property p_fmt_write;
    @(posedge mclk) disable iff (reset)
    (reg_wr && !cfg_lock && reg_addr == mon_cfg_pkg::TEMP_FORMAT_OVERTEMP_CONFIG_ADDR)
      |=> fmt_ff == $past(reg_wdata);
  endproperty
  a_p_fmt_write: assert property (p_fmt_write) else $error("format write lost");

  // Global off keeps the overtemp pin released.
  property p_ovt_off;
    @(posedge mclk) disable iff (reset)
    ovt_off [*2] |-> !ovt_ff;
  endproperty
  a_p_ovt_off: assert property (p_ovt_off) else $error("overtemp driven while off");

  // A hot local channel drives the pin one cycle later.
  property p_local_hot;
    @(posedge mclk) disable iff (reset)
    (hot_loc && !ovt_off) |=> ovt_ff;
  endproperty
  a_p_local_hot: assert property (p_local_hot) else $error("local overtemp missed");

  // Minimum limit in twos mode never drives remote one.
  property p_limit_off;
    @(posedge mclk) disable iff (reset)
    (tw && remote_one_limit == mon_cfg_pkg::LIMIT_OFF_TWOS) |-> !hot_r1;
  endproperty
  a_p_limit_off: assert property (p_limit_off) else $error("disabled limit fired");

  // Reserved alert pin code never drives.
  property p_alert_res;
    @(posedge mclk) disable iff (reset)
    (alert_sel == 2'h3) |-> !alert_pin_oe;
  endproperty
  a_p_alert_res: assert property (p_alert_res) else $error("reserved alert pin driven");

  // Reserved tach pin code never drives.
  property p_tach_res;
    @(posedge mclk) disable iff (reset)
    (tach_sel == 2'h3) |-> !tach_pin_oe && !fan_four_speed_input_sel;
  endproperty
  a_p_tach_res: assert property (p_tach_res) else $error("reserved tach pin driven");

  // All enables clear means no overtemp drive.
  property p_timer_only;
    @(posedge mclk) disable iff (reset)
    (fmt_ff[7:4] == 4'h0) [*2] |-> !ovt_ff && timer_input_only;
  endproperty
  a_p_timer_only: assert property (p_timer_only) else $error("timer input pin driven");
endmodule : mon_cfg_regs
`default_nettype wire

// File: test/mon_cfg_regs_tb.sv
/*
  Self-checking bench for the two lockable configuration registers.
  Assumes the block is driven straight at its ports, with no bus model.
*/
`default_nettype none
module mon_cfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and register port stimulus.
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic cfg_lock = 1'b0;
  // Temperatures and limits in pairs: cpu, remote one, local, remote two.
  logic [7:0] tv [8] = '{default: 8'h00};
  logic smb = 1'b0;
  logic sp_out = 1'b0;
  logic sp_oe = 1'b0;
  // Block outputs.
  logic [7:0] rd;
  logic tw, res, act, drv, tio, a_out, a_oe, t_out, t_oe, fan;
  logic [4:0] byp;
  // Shadow copies of both registers and the run counters.
  logic [7:0] f = 8'h05;
  logic [7:0] p = 8'h00;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  mon_cfg_regs dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(rd), .cfg_lock(cfg_lock), .cpu_temp(tv[0]),
    .cpu_control_limit(tv[1]), .remote_one_temp(tv[2]), .remote_one_limit(tv[3]),
    .local_temp(tv[4]), .local_limit(tv[5]), .remote_two_temp(tv[6]), .remote_two_limit(tv[7]),
    .smbalert_req(smb), .spare_io_three_out(sp_out), .spare_io_three_oe(sp_oe),
    .twos_comp_select(tw), .offset_resolution_select(res), .overtemp_active(act),
    .overtemp_drive(drv), .timer_input_only(tio), .alert_pin_out(a_out), .alert_pin_oe(a_oe),
    .tach_pin_out(t_out), .tach_pin_oe(t_oe), .fan_four_speed_input_sel(fan),
    .term_volt_divider_bypass(byp[0]), .v2p5_divider_bypass(byp[1]),
    .core_volt_divider_bypass(byp[2]), .v5_divider_bypass(byp[3]), .v12_divider_bypass(byp[4]));

  // The clock toggles every 50 ns, a period of 100 ns.
  always #50 mclk = ~mclk;

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // A hung run is cut short and counted as a mismatch.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      final_report();
    end
  end

  // Compares one byte result.
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk8

  // Compares one single-bit result.
  task automatic chk1(input string n, input logic e, input logic s);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", n, e, s);
    end
  endtask : chk1

  // Strict over-limit test; the minimum limit of each encoding switches it off.
  function automatic logic hot(input logic [7:0] t, input logic [7:0] l, input logic c);
    if (l == (c ? 8'h80 : 8'h00))
      return 1'b0;
    return c ? ($signed(t) > $signed(l)) : (t > l);
  endfunction : hot

  // One write cycle; the shadow follows only when the lock is clear.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic lk);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cfg_lock <= lk;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (!lk && a == 8'h7c)
      f = d;
    if (!lk && a == 8'h7d)
      p = d;
  endtask : wr

  // Checks every output against the shadow registers and current inputs.
  task automatic check_all();
    logic ot;
    logic [1:0] ac;
    logic [1:0] tc;
    ot = ~p[2] & (f[4] & hot(tv[0], tv[1], f[0]) | f[5] & hot(tv[2], tv[3], f[0])
      | f[6] & hot(tv[4], tv[5], f[0]) | f[7] & hot(tv[6], tv[7], f[0]));
    ac = f[3:2];
    tc = p[1:0];
    @(negedge mclk);
    chk1("twos", f[0], tw);
    chk1("offset_res", f[1], res);
    chk1("overtemp", ot, act);
    chk1("overtemp_drive", ot, drv);
    chk1("timer_only", p[2] | f[7:4] == 4'h0, tio);
    chk1("alert_out", ac == 2'h2 && sp_out, a_out);
    chk1("alert_oe", ac == 2'h0 ? smb : ac == 2'h1 ? ot : ac == 2'h2 && sp_oe, a_oe);
    chk1("tach_out", 1'b0, t_out);
    chk1("tach_oe", tc == 2'h1 ? ot : tc == 2'h2 && smb, t_oe);
    chk1("fan_sel", tc == 2'h0, fan);
    chk8("bypass", {3'h0, p[7:3]}, {3'h0, byp});
    foreach (tv[i])
    begin
      @(posedge mclk);
      reg_addr <= 8'h7a + 8'(i);
      @(negedge mclk);
      chk8("readback", i == 2 ? f : i == 3 ? p : 8'h00, rd);
    end
  endtask : check_all

  // One write from the arguments, then random temperatures, limits and pin requests.
  task automatic step(input logic [7:0] a, input logic [7:0] d, input logic lk);
    logic [7:0] v;
    wr(a, d, lk);
    @(posedge mclk);
    foreach (tv[i])
    begin
      v = f[0] ? 8'($urandom_range(127)) - 8'h40 : 8'($urandom);
      if (i % 2 == 1 && $urandom_range(4) == 0)
        v = f[0] ? 8'h80 : 8'h00;
      tv[i] <= v;
    end
    smb <= 1'($urandom);
    sp_out <= 1'($urandom);
    sp_oe <= 1'($urandom);
    @(posedge mclk);
    check_all();
  endtask : step

  // Main sequence: reset values, corner cases, then random traffic.
  initial
  begin
    void'($urandom(95));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    check_all();
    // timer limit left to software.
    // The timer limit register is outside this block, so software owns that setting.
    step(8'h7c, 8'hf5, 1'b0);
    step(8'h7d, 8'hff, 1'b1);
    step(8'h7e, 8'h5a, 1'b0);
    repeat (300)
      step(8'h7c + 8'($urandom_range(2)), 8'($urandom), $urandom_range(3) == 0);
    final_report();
  end
endmodule : mon_cfg_regs_tb
`default_nettype wire
